// ==== dfm_top.sv ====
// drive fault monitor: detection, trip control, history and register bus
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module dfm_top #(
   parameter int CYC_PER_MS_P = dfm_pkg::CYC_PER_MS
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // register bus
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // supervision pins
   input  wire logic        mainsOkIn,
   input  wire logic        unattendedStartLockoutInput,
   input  wire logic        groundFaultIn,
   input  wire logic        supplyOverIn,
   input  wire logic [2:0]  phasePresentIn,
   input  wire logic        overTempIn,
   input  wire logic        linkErrorIn,
   input  wire logic        transistorOcIn,
   input  wire logic        thermistorHighIn,
   input  wire logic        brakeAckIn,
   input  wire logic        lowVoltageIn,
   input  wire logic        moduleOneReq,
   input  wire logic [3:0]  moduleOneSub,
   input  wire logic        moduleTwoReq,
   input  wire logic [3:0]  moduleTwoSub,
   // keypad pins
   input  wire logic        offKeyIn,
   input  wire logic        resetInputIn,
   input  wire logic        standbyIn,
   // drive logic
   input  wire logic [3:0]  driveState,
   input  wire logic        brakeCmd,
   input  wire logic [15:0] outFreq,
   input  wire logic [15:0] motorCurrent,
   input  wire logic [15:0] dcLinkVolt,
   input  wire logic [31:0] runTime,
   input  wire logic [31:0] mainsOnTime,
   // power stage and keypad
   output logic             outputEnable,
   output logic             tripActive,
   output logic [11:0]      faultCode,
   output logic             standbyInd,
   output logic             countdownInd,
   output logic             initInd
);
   import dfm_pkg::*;

   function automatic logic [3:0] subClamp(input logic [3:0] v);
      subClamp = (v > SUB_MAX) ? SUB_MAX : v;
   endfunction

   function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] st);
      wr16 = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
   endfunction

   logic [25:0]     pinSync;
   logic            mainsOkS;
   logic            uslS;
   logic            gndS;
   logic            supOvS;
   logic [2:0]      phaseS;
   logic            otS;
   logic            linkS;
   logic            ocS;
   logic            ptcS;
   logic            brakeAckS;
   logic            lowVS;
   logic            mod1S;
   logic [3:0]      mod1SubS;
   logic            mod2S;
   logic [3:0]      mod2SubS;
   logic            offKeyS;
   logic            resetInS;
   logic            standbyS;

   dfm_sync #(.W(26)) u_sync (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .asyncIn ({standbyIn, resetInputIn, offKeyIn, moduleTwoSub, moduleTwoReq,
                 moduleOneSub, moduleOneReq, lowVoltageIn, brakeAckIn, thermistorHighIn,
                 transistorOcIn, linkErrorIn, overTempIn, phasePresentIn, supplyOverIn,
                 groundFaultIn, unattendedStartLockoutInput, mainsOkIn}),
      .syncOut (pinSync)
   );
   assign {standbyS, resetInS, offKeyS, mod2SubS, mod2S, mod1SubS, mod1S, lowVS, brakeAckS,
           ptcS, ocS, linkS, otS, phaseS, supOvS, gndS, uslS, mainsOkS} = pinSync;

   logic [16:0]     msCnt_reg;
   logic            msTick_reg;
   logic [16:0]     powerMs_reg;
   logic [15:0]     dropMs_reg;
   logic            mainsPrev_reg;
   logic            offKeyPrev_reg;
   logic            brakeCmdPrev_reg;
   logic            brakeWait_reg;
   logic [15:0]     brakeMs_reg;
   logic [15:0]     dropTol_reg;
   logic [15:0]     brakeTo_reg;
   logic [15:0]     restartWait_reg;
   logic            restartMode_reg;
   logic            initReq_reg;
   logic            swAck_reg;
   dfm_state_t      state_reg;
   logic [15:0]     waitMs_reg;
   logic [7:0]      lastCode_reg;
   logic [3:0]      lastSub_reg;
   logic            mainsUp;
   logic            brakeLate;
   logic            detHit;
   logic [7:0]      detCode;
   logic            tripNow;
   logic [7:0]      tripCode;
   logic            ackReq;
   logic [EW-1:0]   pushEntry;
   logic [EW-1:0]   histEntry;
   logic            histValid;
   logic            initBusy;
   logic [2:0]      rdSlot;

   // millisecond time base
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         msCnt_reg <= 17'h0;
         msTick_reg <= 1'b0;
      end else begin
         msTick_reg <= (msCnt_reg == 17'(CYC_PER_MS_P - 1));
         msCnt_reg <= (msCnt_reg == 17'(CYC_PER_MS_P - 1)) ? 17'h0 : msCnt_reg + 17'h1;
      end
   end

   // powered time and dropout length
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         powerMs_reg <= 17'h0;
         dropMs_reg <= 16'h0;
         mainsPrev_reg <= 1'b0;
         offKeyPrev_reg <= 1'b0;
      end else begin
         mainsPrev_reg <= mainsOkS;
         offKeyPrev_reg <= offKeyS;
         if (!mainsOkS) begin
            powerMs_reg <= 17'h0;
         end else if (msTick_reg && powerMs_reg != OV_DELAY_MS) begin
            powerMs_reg <= powerMs_reg + 17'h1;
         end
         if (mainsUp) begin
            dropMs_reg <= 16'h0;
         end else if (!mainsOkS && msTick_reg && dropMs_reg != 16'hffff) begin
            dropMs_reg <= dropMs_reg + 16'h1;
         end
      end
   end
   assign mainsUp = mainsOkS && !mainsPrev_reg;

   // brake acknowledge supervision
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         brakeCmdPrev_reg <= 1'b0;
         brakeWait_reg <= 1'b0;
         brakeMs_reg <= 16'h0;
      end else begin
         brakeCmdPrev_reg <= brakeCmd;
         if (brakeAckS || !brakeCmd || state_reg == DFM_TRIP) begin
            brakeWait_reg <= 1'b0;
            brakeMs_reg <= 16'h0;
         end else if (!brakeCmdPrev_reg) begin
            brakeWait_reg <= 1'b1;
            brakeMs_reg <= 16'h0;
         end else if (brakeWait_reg && msTick_reg && brakeMs_reg != 16'hffff) begin
            brakeMs_reg <= brakeMs_reg + 16'h1;
         end
      end
   end
   assign brakeLate = brakeWait_reg && (brakeMs_reg >= brakeTo_reg);

   // fault detection, highest priority first
   always_comb begin
      detHit = 1'b1;
      detCode = F_UNDERV;
      if (mainsUp && uslS) begin
         detCode = F_LOCK;
      end else if (gndS) begin
         detCode = F_GND;
      end else if (supOvS && powerMs_reg == OV_DELAY_MS) begin
         detCode = F_OVV;
      end else if (mainsUp && dropMs_reg >= DROP_MIN_MS && dropMs_reg > dropTol_reg) begin
         detCode = F_DROP;
      end else if (otS) begin
         detCode = F_OTEMP;
      end else if (linkS) begin
         detCode = F_LINK;
      end else if (mainsOkS && phaseS != 3'h7) begin
         detCode = F_PHASE;
      end else if (ocS) begin
         detCode = F_IGBT;
      end else if (ptcS) begin
         detCode = F_PTC;
      end else if (brakeLate) begin
         detCode = F_BRAKE;
      end else if (mod1S) begin
         detCode = F_MOD1 + {4'h0, subClamp(mod1SubS)};
      end else if (mod2S) begin
         detCode = F_MOD2 + {4'h0, subClamp(mod2SubS)};
      end else begin
         detHit = 1'b0;
      end
   end

   // low voltage trips at once with restart mode off, otherwise only once the restart wait has run out
   assign tripNow = (state_reg == DFM_RUN && (detHit || (lowVS && !restartMode_reg))) ||
                    (state_reg == DFM_WAIT && (detHit || (waitMs_reg == 16'h0 && lowVS)));
   assign tripCode = detHit ? detCode : F_UNDERV;
   assign ackReq = (offKeyS && !offKeyPrev_reg) || resetInS || swAck_reg;
   assign pushEntry = {mainsOnTime, runTime, dcLinkVolt, motorCurrent, outFreq,
                       subClamp(driveState), tripCode};

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= DFM_RUN;
         waitMs_reg <= 16'h0;
         lastCode_reg <= 8'h00;
         lastSub_reg <= 4'h0;
      end else if (tripNow) begin
         state_reg <= DFM_TRIP;
         lastCode_reg <= tripCode;
         lastSub_reg <= subClamp(driveState);
      end else begin
         case (state_reg)
            DFM_RUN: begin
               if (lowVS) begin
                  state_reg <= DFM_WAIT;
                  waitMs_reg <= restartWait_reg;
               end
            end
            DFM_WAIT: begin
               if (waitMs_reg == 16'h0) begin
                  state_reg <= DFM_RUN;
               end else if (msTick_reg) begin
                  waitMs_reg <= waitMs_reg - 16'h1;
               end
            end
            DFM_TRIP: begin
               if (ackReq) begin
                  state_reg <= DFM_RUN;
               end
            end
            default: begin
               state_reg <= DFM_RUN;
            end
         endcase
      end
   end

   dfm_history u_hist (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .push      (tripNow),
      .pushEntry (pushEntry),
      .initReq   (initReq_reg),
      .initBusy  (initBusy),
      .rdSlot    (rdSlot),
      .rdEntry   (histEntry),
      .rdValid   (histValid)
   );

   // outputs to power stage and keypad
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         outputEnable <= 1'b0;
         tripActive <= 1'b0;
         faultCode <= 12'h000;
         standbyInd <= 1'b0;
         countdownInd <= 1'b0;
         initInd <= 1'b0;
      end else begin
         outputEnable <= state_reg == DFM_RUN && !tripNow && !lowVS && mainsOkS &&
                         !standbyS && !resetInS && !initBusy;
         tripActive <= state_reg == DFM_TRIP || tripNow;
         faultCode <= {lastSub_reg, lastCode_reg};
         standbyInd <= standbyS || resetInS;
         countdownInd <= state_reg == DFM_WAIT;
         initInd <= initBusy;
      end
   end

   // register bus write side
   logic            awHave_reg;
   logic [7:0]      awAddr_reg;
   logic            wHave_reg;
   logic [31:0]     wData_reg;
   logic [3:0]      wStrb_reg;
   logic            doWrite;
   assign doWrite = awHave_reg && wHave_reg && !s_axi_bvalid;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         awHave_reg <= 1'b0;
         awAddr_reg <= 8'h00;
         wHave_reg <= 1'b0;
         wData_reg <= 32'h0;
         wStrb_reg <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHave_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            awHave_reg <= 1'b0;
            wHave_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr_reg <= A_RWAIT) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // configuration registers and command pulses
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dropTol_reg <= DTOL_RST;
         brakeTo_reg <= BTO_RST;
         restartWait_reg <= RWAIT_RST;
         restartMode_reg <= RMODE_RST;
         initReq_reg <= 1'b0;
         swAck_reg <= 1'b0;
      end else begin
         initReq_reg <= 1'b0;
         swAck_reg <= 1'b0;
         if (doWrite) begin
            case (awAddr_reg)
               A_CTRL: begin
                  initReq_reg <= wStrb_reg[0] && wData_reg[CTRL_INIT];
                  swAck_reg <= wStrb_reg[0] && wData_reg[CTRL_ACK];
               end
               A_DTOL: dropTol_reg <= wr16(dropTol_reg, wData_reg, wStrb_reg);
               A_BTO: brakeTo_reg <= wr16(brakeTo_reg, wData_reg, wStrb_reg);
               A_RMODE: begin
                  if (wStrb_reg[0]) begin
                     restartMode_reg <= wData_reg[0];
                  end
               end
               A_RWAIT: restartWait_reg <= wr16(restartWait_reg, wData_reg, wStrb_reg);
               default: begin
               end
            endcase
         end
      end
   end

   // register bus read side
   logic [31:0]     rdNext;
   logic [1:0]      rrespNext;

   always_comb begin
      rdNext = 32'h0;
      rrespNext = RESP_OKAY;
      rdSlot = 3'(s_axi_araddr[7:5] - 3'h2);
      if (s_axi_araddr >= A_HIST) begin
         case (s_axi_araddr[4:2])
            3'h0: rdNext = histValid ? {20'h0, histEntry[E_SUB +: 4],
                                        histEntry[E_CODE +: 8]} : NO_DATA;
            3'h1: rdNext = {16'h0, histEntry[E_FREQ +: 16]};
            3'h2: rdNext = {16'h0, histEntry[E_CUR +: 16]};
            3'h3: rdNext = {16'h0, histEntry[E_DC +: 16]};
            3'h4: rdNext = histEntry[E_RUN +: 32];
            3'h5: rdNext = histEntry[E_MON +: 32];
            default: rdNext = 32'h0;
         endcase
      end else begin
         case (s_axi_araddr)
            A_CTRL: rdNext = 32'h0;
            A_STAT: begin
               rdNext[ST_TRIP] = tripActive;
               rdNext[ST_OE] = outputEnable;
               rdNext[ST_STBY] = standbyInd;
               rdNext[ST_CNT] = countdownInd;
               rdNext[ST_INIT] = initInd;
               rdNext[ST_CODE +: 12] = faultCode;
            end
            A_DTOL: rdNext = {16'h0, dropTol_reg};
            A_BTO: rdNext = {16'h0, brakeTo_reg};
            A_RMODE: rdNext = {31'h0, restartMode_reg};
            A_RWAIT: rdNext = {16'h0, restartWait_reg};
            default: rrespNext = RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdNext;
         s_axi_rresp <= rrespNext;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule

// ==== dfm_pkg.sv ====
// shared constants and types of the drive fault monitor
package dfm_pkg;
   // timing
   localparam int CLK_HZ = 125_000_000;
   localparam int MS_PER_S = 1000;
   localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
   localparam int OV_DELAY_S = 100;
   localparam logic [16:0] OV_DELAY_MS = 17'(OV_DELAY_S * MS_PER_S);
   localparam logic [15:0] DROP_MIN_MS = 16'h000f;
   // history layout
   localparam int HIST_N = 6;
   localparam int EW = 124;
   localparam int E_CODE = 0;
   localparam int E_SUB = 8;
   localparam int E_FREQ = 12;
   localparam int E_CUR = 28;
   localparam int E_DC = 44;
   localparam int E_RUN = 60;
   localparam int E_MON = 92;
   localparam logic [31:0] NO_DATA = 32'h0000_ffff;
   // fault codes
   localparam logic [7:0] F_UNDERV = 8'h09;
   localparam logic [7:0] F_LOCK = 8'h0d;
   localparam logic [7:0] F_GND = 8'h0e;
   localparam logic [7:0] F_OVV = 8'h0f;
   localparam logic [7:0] F_DROP = 8'h10;
   localparam logic [7:0] F_OTEMP = 8'h15;
   localparam logic [7:0] F_LINK = 8'h17;
   localparam logic [7:0] F_PHASE = 8'h18;
   localparam logic [7:0] F_IGBT = 8'h1e;
   localparam logic [7:0] F_PTC = 8'h23;
   localparam logic [7:0] F_BRAKE = 8'h24;
   localparam logic [7:0] F_MOD1 = 8'h3c;
   localparam logic [7:0] F_MOD2 = 8'h46;
   localparam logic [3:0] SUB_MAX = 4'h9;
   // register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_DTOL = 8'h08;
   localparam logic [7:0] A_BTO = 8'h0c;
   localparam logic [7:0] A_RMODE = 8'h10;
   localparam logic [7:0] A_RWAIT = 8'h14;
   localparam logic [7:0] A_HIST = 8'h40;
   // reset values
   localparam logic [15:0] DTOL_RST = 16'h0064;
   localparam logic [15:0] BTO_RST = 16'h0064;
   localparam logic [15:0] RWAIT_RST = 16'h03e8;
   localparam logic RMODE_RST = 1'b1;
   // field positions
   localparam int CTRL_INIT = 0;
   localparam int CTRL_ACK = 1;
   localparam int ST_TRIP = 0;
   localparam int ST_OE = 1;
   localparam int ST_STBY = 2;
   localparam int ST_CNT = 3;
   localparam int ST_INIT = 4;
   localparam int ST_CODE = 12;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {DFM_RUN, DFM_WAIT, DFM_TRIP} dfm_state_t;
endpackage

// ==== dfm_sync.sv ====
// two-stage synchroniser for a group of pin levels
`timescale 1ns/100ps
module dfm_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   // levels
   input  wire logic [W-1:0] asyncIn,
   output logic [W-1:0]      syncOut
);
   import dfm_pkg::*;
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
         end else begin
            meta_reg <= asyncIn[i];
            sync_reg <= meta_reg;
         end
      end
      assign syncOut[i] = sync_reg;
   end
endmodule

// ==== dfm_history.sv ====
// six-entry shifting fault history with sequential clear
`timescale 1ns/100ps
module dfm_history (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   resetn,
   // new entry and clear
   input  wire logic                   push,
   input  wire logic [dfm_pkg::EW-1:0] pushEntry,
   input  wire logic                   initReq,
   output logic                        initBusy,
   // read port
   input  wire logic [2:0]             rdSlot,
   output logic [dfm_pkg::EW-1:0]      rdEntry,
   output logic                        rdValid
);
   import dfm_pkg::*;
   logic [EW:0] slotBus [HIST_N];
   logic [2:0]  initCnt_reg;
   logic        initBusy_reg;

   // one slot cleared per cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         initBusy_reg <= 1'b0;
         initCnt_reg <= 3'h0;
      end else if (initBusy_reg) begin
         if (initCnt_reg == 3'(HIST_N - 1)) begin
            initBusy_reg <= 1'b0;
         end
         initCnt_reg <= initCnt_reg + 3'h1;
      end else if (initReq) begin
         initBusy_reg <= 1'b1;
         initCnt_reg <= 3'h0;
      end
   end

   for (genvar s = 0; s < HIST_N; s++) begin : g_slot
      logic [EW:0] slot_reg;
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            slot_reg <= '0;
         end else if (initBusy_reg) begin
            if (initCnt_reg == 3'(s)) begin
               slot_reg <= '0;
            end
         end else if (push) begin
            if (s == 0) begin
               slot_reg <= {1'b1, pushEntry};
            end else begin
               slot_reg <= slotBus[s - (s > 0)];
            end
         end
      end
      assign slotBus[s] = slot_reg;
   end

   always_comb begin
      rdEntry = '0;
      rdValid = 1'b0;
      if (rdSlot < 3'(HIST_N)) begin
         rdEntry = slotBus[rdSlot][EW-1:0];
         rdValid = slotBus[rdSlot][EW];
      end
   end

   assign initBusy = initBusy_reg;
endmodule

// ==== dfm_assertions.sv ====
// concurrent checks on the drive fault monitor ports
`timescale 1ns/100ps
module dfm_checker (
   // clock, reset and pins
   input wire logic        sys_clk, resetn, groundFaultIn, resetInputIn, offKeyIn, standbyIn,
   // bus and outputs
   input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
   input wire logic        s_axi_rvalid, s_axi_rready, outputEnable, tripActive, standbyInd,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [11:0] faultCode
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   trip_holds_off_a: assert property (tripActive && $past(tripActive) |-> !outputEnable)
      else $error("output enabled while tripped");
   code_frozen_a: assert property (tripActive && $past(tripActive, 2)
      |-> $stable(faultCode)) else $error("fault code changed while tripped");
   ground_trips_a: assert property ((groundFaultIn && !resetInputIn && !offKeyIn)[*5]
      |-> tripActive) else $error("earth fault did not trip");
   suffix_range_a: assert property (tripActive |-> faultCode[11:8] <= 4'h9)
      else $error("state suffix out of range");
   standby_ind_a: assert property ((standbyIn || resetInputIn)[*5] |-> standbyInd)
      else $error("standby indication missing");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
   read_answer_a: assert property ($rose(s_axi_rvalid)
      |-> $past(s_axi_arvalid) && $past(s_axi_arready)) else $error("read answer without request");
endmodule
bind dfm_top dfm_checker CHK (.*);

// ==== dfm_brake_model.sv ====
// brake that acknowledges a command after a delay
`timescale 1ns/100ps
module dfm_brake_model #(
   parameter int DLY = 5
) (
   input wire logic sys_clk, brakeCmd, ackOn,
   output logic     brakeAckIn = 1'b0
);
   int cnt = 0;
   // ack comes DLY+1 cycles into the command, well inside the timeout
   always @(posedge sys_clk) begin
      cnt <= brakeCmd ? cnt + 1 : 0;
      brakeAckIn <= ackOn && brakeCmd && cnt >= DLY;
   end
endmodule

// ==== tb_drive_fault_monitor_history.sv ====
// self-checking bench for the fault monitor
`timescale 1ns/100ps
module tb_drive_fault_monitor_history;
   import dfm_pkg::*;
   logic        sys_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_rready, offKeyIn, resetInputIn, standbyIn, lowVoltageIn, brakeCmd, ackOn;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        outputEnable, tripActive, standbyInd, countdownInd, initInd, brakeAckIn;
   logic        mainsOkIn, unattendedStartLockoutInput, supplyOverIn, groundFaultIn, overTempIn;
   logic        linkErrorIn, transistorOcIn, thermistorHighIn, moduleOneReq, moduleTwoReq;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [2:0]  phasePresentIn;
   logic [3:0]  s_axi_wstrb, moduleOneSub, moduleTwoSub, driveState;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, flt;
   logic [11:0] faultCode;
   logic [15:0] outFreq, motorCurrent, dcLinkVolt, snap;
   logic [31:0] s_axi_wdata, s_axi_rdata, runTime, mainsOnTime;
   int          errors, checks_done;
   localparam logic [7:0] CODE [8] = '{F_GND, F_OTEMP, F_LINK, F_IGBT, F_PTC, F_PHASE,
                                       F_MOD1 + 8'h03, F_MOD2 + 8'h03};
   assign {mainsOkIn, unattendedStartLockoutInput, supplyOverIn} = 3'b100;
   assign {moduleOneSub, moduleTwoSub} = 8'h33;
   assign {thermistorHighIn, transistorOcIn, linkErrorIn, overTempIn, groundFaultIn} = flt[4:0];
   assign {moduleTwoReq, moduleOneReq, phasePresentIn} = {flt[7:6], 2'b11, ~flt[5]};
   assign {outFreq, motorCurrent, dcLinkVolt, runTime, mainsOnTime} = {7{snap}};
   dfm_top #(.CYC_PER_MS_P(10)) DUT (.*);
   dfm_brake_model #(.DLY(5)) PM (.*);
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task summarize;
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task ck(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task tmo(input int n);
      if (n >= 60) begin
         errors++;
         summarize();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 60);
      s_axi_bready <= 1'b0;
      tmo(n);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      int n = 0;
      @(posedge sys_clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
      do begin @(posedge sys_clk); n++; end while (!s_axi_arready && n < 60);
      s_axi_arvalid <= 1'b0;
      do begin @(posedge sys_clk); n++; end while (!s_axi_rvalid && n < 60);
      s_axi_rready <= 1'b0;
      tmo(n);
      ck(s_axi_rdata, e);
      ck({30'h0, s_axi_rresp}, {30'h0, r});
   endtask
   task ack(input bit key);
      if (key) begin
         @(posedge sys_clk) offKeyIn <= 1'b1;
         @(posedge sys_clk) offKeyIn <= 1'b0;
      end else wr(A_CTRL, 32'h2);
      repeat (8) @(posedge sys_clk);
   endtask
   task t_regs;
      rd(A_DTOL, {16'h0, DTOL_RST}, RESP_OKAY);
      rd(A_BTO, {16'h0, BTO_RST}, RESP_OKAY);
      rd(A_RWAIT, {16'h0, RWAIT_RST}, RESP_OKAY);
      rd(A_RMODE, {31'h0, RMODE_RST}, RESP_OKAY);
      rd(8'h18, 32'h0, RESP_SLVERR);
      rd(A_HIST + 8'ha0, NO_DATA, RESP_OKAY);
   endtask
   task t_faults;
      for (int i = 0; i < 8; i++) begin
         {driveState, snap, flt} <= {4'(i), 16'h0100 + 16'(i), 8'h01 << i};
         repeat (6) @(posedge sys_clk);
         ck({20'h0, faultCode}, {20'h0, 4'(i), CODE[i]});
         flt <= 8'h00;
         repeat (10) @(posedge sys_clk);
         ck({31'h0, outputEnable}, 32'h0);
         ack(i[0]);
         ck({30'h0, outputEnable, tripActive}, 32'h2);
      end
      rd(A_HIST, {20'h0, 4'h7, CODE[7]}, RESP_OKAY);
      rd(A_HIST + 8'h04, 32'h0107, RESP_OKAY);
      rd(A_HIST + 8'ha0, {20'h0, 4'h2, CODE[2]}, RESP_OKAY);
   endtask
   task t_brake;
      {driveState, ackOn} <= 5'h01;
      wr(A_BTO, 32'h2);
      brakeCmd <= 1'b1;
      repeat (40) @(posedge sys_clk);
      ck({31'h0, tripActive}, 32'h0);
      {brakeCmd, ackOn} <= 2'b00;
      repeat (4) @(posedge sys_clk);
      brakeCmd <= 1'b1;
      repeat (40) @(posedge sys_clk);
      ck({20'h0, faultCode}, {24'h0, F_BRAKE});
      brakeCmd <= 1'b0;
      ack(1'b1);
   endtask
   task t_low;
      wr(A_RWAIT, 32'h2);
      lowVoltageIn <= 1'b1;
      repeat (8) @(posedge sys_clk);
      ck({31'h0, countdownInd}, 32'h1);
      repeat (40) @(posedge sys_clk);
      ck({20'h0, faultCode}, {24'h0, F_UNDERV});
      lowVoltageIn <= 1'b0;
      ack(1'b0);
   endtask
   task t_standby;
      standbyIn <= 1'b1;
      repeat (6) @(posedge sys_clk);
      ck({30'h0, standbyInd, outputEnable}, 32'h2);
      {standbyIn, resetInputIn} <= 2'b01;
      repeat (6) @(posedge sys_clk);
      ck({31'h0, standbyInd}, 32'h1);
      resetInputIn <= 1'b0;
      wr(A_CTRL, 32'h1);
      repeat (2) @(posedge sys_clk);
      ck({31'h0, initInd}, 32'h1);
      repeat (10) @(posedge sys_clk);
      rd(A_HIST, NO_DATA, RESP_OKAY);
   endtask
   initial begin
      {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      {offKeyIn, resetInputIn, standbyIn, lowVoltageIn, brakeCmd, ackOn, flt, snap} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, driveState} = 0;
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      t_regs();
      t_faults();
      t_brake();
      t_low();
      t_standby();
      summarize();
   end
endmodule
